/* shared/cnp_consts.vh */
// Constants for the thermistor profile and live charger status register slice.
`ifndef CNP_CONSTS_VH
`define CNP_CONSTS_VH

// Register addresses on the serial port.
`define CNP_ADDR_THRESH_A   8'h1B
`define CNP_ADDR_PROFILE_B  8'h1C
`define CNP_ADDR_STATUS_A   8'h1D

// Reset values.
`define CNP_RST_THRESH_A    8'h25
`define CNP_RST_PROFILE_B   8'h3F
`define CNP_RST_STATUS_A    8'h00

// Writable bits of the profile register; bit 7 is reserved.
`define CNP_MASK_PROFILE_B  8'h7F

// Fields of the threshold register.
`define CNP_COLD_HI         7
`define CNP_COLD_LO         5
`define CNP_HOT_HI          4
`define CNP_HOT_LO          2
`define CNP_WARMV_HI        1
`define CNP_WARMV_LO        0

// Fields of the profile register.
`define CNP_MIRROR_BIT      6
`define CNP_PREWV_HI        5
`define CNP_PREWV_LO        4
`define CNP_PREWI_HI        3
`define CNP_PREWI_LO        2
`define CNP_PRECI_HI        1
`define CNP_PRECI_LO        0

// Bits of the status register.
`define CNP_ST_ADC          6
`define CNP_ST_DIETHERM     5
`define CNP_ST_MINSYS       4
`define CNP_ST_ICURR        3
`define CNP_ST_IVOLT        2
`define CNP_ST_TIMER        1
`define CNP_ST_WDOG         0

// Thermistor zone codes.
`define CNP_ZONE_NORMAL     3'h0
`define CNP_ZONE_COLD       3'h1
`define CNP_ZONE_HOT        3'h2
`define CNP_ZONE_COOL       3'h3
`define CNP_ZONE_WARM       3'h4
`define CNP_ZONE_PRECOOL    3'h5
`define CNP_ZONE_PREWARM    3'h6
`define CNP_ZONE_BIASFAULT  3'h7

// Derating codes: leave unchanged, and suspend charging.
`define CNP_CODE_UNCHANGED  2'h3
`define CNP_CODE_SUSPEND    2'h0

// Serial byte framing.
`define CNP_BITS_PER_BYTE   4'h8
`define CNP_LAST_TX_BIT     4'h7

`endif

/* verilog/cnp_sync.v */
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module cnp_sync #(
    parameter W = 1
) (
    // Clock and reset.
    input  wire         sys_clk,
    input  wire         sys_rst,
    // Asynchronous inputs and their accepted values.
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut
);

    reg [W-1:0] stageOne;   // First stage, read only by the second.
    reg [W-1:0] stageTwo;   // Second stage.
    reg [W-1:0] stageThree; // Third stage.

    // Each bit moves to the output only when the last two stages agree.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stageOne   <= {W{1'b0}};
            stageTwo   <= {W{1'b0}};
            stageThree <= {W{1'b0}};
            syncOut    <= {W{1'b0}};
        end else begin
            stageOne   <= asyncIn;
            stageTwo   <= stageOne;
            stageThree <= stageTwo;
            syncOut    <= (stageTwo & stageThree) | (syncOut & (stageTwo | stageThree));
        end
    end

endmodule
`default_nettype wire

/* verilog/cnp_regs.v */
// Serial-port register slice for thermistor profile control and live charger status.
`timescale 1ns/1ps
`default_nettype none
`include "cnp_consts.vh"

module cnp_regs #(
    parameter [6:0] DEV_ADDR = 7'h35 // Serial target address, value arbitrary.
) (
    // Clock and reset.
    input  wire       sys_clk,
    input  wire       sys_rst,
    // Serial port pins; the data pin is open drain.
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOut,
    output reg        sdaOe,
    // Live conditions from the charger's analog loops.
    input  wire       adcOneShotDone,
    input  wire       adcContinuous,
    input  wire       forwardMode,
    input  wire       dieThermalRegulating,
    input  wire       batteryBelowMinSystem,
    input  wire       inputCurrentLoop,
    input  wire       pinCurrentLimitLoop,
    input  wire       inputVoltageLoop,
    input  wire       chargeTimerExpired,
    input  wire       hostWatchdogExpired,
    // Present thermistor zone code.
    input  wire [2:0] zoneCode,
    // Settings handed to the comparators and regulation loops.
    output reg  [2:0] coldSideThresholdSelect,
    output reg  [2:0] hotSideThresholdSelect,
    output reg  [1:0] voltageOffsetCode,
    output reg  [1:0] currentScaleCode
);

    // Serial engine states.
    localparam [2:0] ST_IDLE = 3'h0; // Waiting for a start condition.
    localparam [2:0] ST_RX   = 3'h1; // Shifting a byte in.
    localparam [2:0] ST_ACK  = 3'h2; // Driving our acknowledge bit.
    localparam [2:0] ST_TX   = 3'h3; // Shifting a byte out.
    localparam [2:0] ST_MACK = 3'h4; // Sampling the host's acknowledge.

    // Kinds of received byte.
    localparam [1:0] KIND_DEV  = 2'h0; // Target address and direction.
    localparam [1:0] KIND_REG  = 2'h1; // Register pointer.
    localparam [1:0] KIND_DATA = 2'h2; // Write data.

    // Reset image of the threshold register, sliced for the settings outputs.
    localparam [7:0] RST_THRESH = `CNP_RST_THRESH_A;

    // Synchronised pins and conditions.
    wire [1:0]  pinSync;     // {scl, sda} after the synchroniser.
    wire [10:0] condSync;    // Live conditions after the synchroniser.
    wire [2:0]  zoneSync;    // Zone code after the synchroniser.
    wire        sclNow;      // Accepted clock level.
    wire        sdaNow;      // Accepted data level.
    wire [7:0]  readByte;    // Byte a read of the pointed register returns.

    // Pin history for edge and condition detection.
    reg         sclPrev;     // Clock level one cycle earlier.
    reg         sdaPrev;     // Data level one cycle earlier.
    wire        sclRise;     // Clock rose this cycle.
    wire        sclFall;     // Clock fell this cycle.
    wire        startSeen;   // Data fell while clock high.
    wire        stopSeen;    // Data rose while clock high.

    // Serial engine state.
    reg [2:0]   state;       // Current engine state.
    reg [1:0]   kind;        // Kind of the byte in flight.
    reg [3:0]   bitCnt;      // Bits shifted in the current byte.
    reg [7:0]   shiftReg;    // Byte being shifted.
    reg [7:0]   regPtr;      // Register pointer, advances per data byte.
    reg         readDir;     // Transfer direction, high for read.
    reg         hostAcked;   // Host acknowledged the last byte sent.

    // The three registers.
    reg [7:0]   threshControlA;  // Cold and hot thresholds, warm voltage.
    reg [7:0]   profileControlB; // Pre-zone derating and mirror control.
    reg [7:0]   liveStatusA;     // Live charger status.
    reg [7:0]   next_liveStatus; // Next value of the status register.

    // Zone derating, computed before registering.
    reg [1:0]   next_voltageOffset;
    reg [1:0]   next_currentScale;

    assign sclNow    = pinSync[1];
    assign sdaNow    = pinSync[0];
    assign sclRise   = sclNow & ~sclPrev;
    assign sclFall   = ~sclNow & sclPrev;
    assign startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
    assign stopSeen  = sclNow & sclPrev & ~sdaPrev & sdaNow;

    // Read decode; unmapped addresses read as zero and reads have no side effect.
    function [7:0] readMux;
        input [7:0] addr;
        input [7:0] thresh;
        input [7:0] profile;
        input [7:0] status;
        begin
            case (addr)
                `CNP_ADDR_THRESH_A:  readMux = thresh;
                `CNP_ADDR_PROFILE_B: readMux = profile & `CNP_MASK_PROFILE_B;
                `CNP_ADDR_STATUS_A:  readMux = status;
                default:             readMux = 8'h00;
            endcase
        end
    endfunction

    assign readByte = readMux(regPtr, threshControlA, profileControlB, liveStatusA);

    // Pins pass three stages before the engine sees them.
    cnp_sync #(
        .W(2)
    ) uPinSync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn({sclIn, sdaIn}),
        .syncOut(pinSync)
    );

    // Analog conditions and zone code cross in the same way.
    cnp_sync #(
        .W(14)
    ) uCondSync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn({adcOneShotDone, adcContinuous, forwardMode, dieThermalRegulating,
                  batteryBelowMinSystem, inputCurrentLoop, pinCurrentLimitLoop,
                  inputVoltageLoop, chargeTimerExpired, hostWatchdogExpired,
                  1'b0, zoneCode}),
        .syncOut({condSync, zoneSync})
    );

    // Status bits follow the live conditions every cycle.
    always @* begin
        next_liveStatus = `CNP_RST_STATUS_A;
        next_liveStatus[`CNP_ST_ADC]      = condSync[10] & ~condSync[9];
        next_liveStatus[`CNP_ST_DIETHERM] = condSync[7];
        next_liveStatus[`CNP_ST_MINSYS]   = condSync[8] & condSync[6];
        next_liveStatus[`CNP_ST_ICURR]    = condSync[8] & (condSync[5] | condSync[4]);
        next_liveStatus[`CNP_ST_IVOLT]    = condSync[8] & condSync[3];
        next_liveStatus[`CNP_ST_TIMER]    = condSync[2];
        next_liveStatus[`CNP_ST_WDOG]     = condSync[1];
    end

    // The status register is never written by the host, only refreshed.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            liveStatusA <= `CNP_RST_STATUS_A;
        end else begin
            liveStatusA <= next_liveStatus;
        end
    end

    // Pick the voltage and current derating for the present zone.
    always @* begin
        next_voltageOffset = `CNP_CODE_UNCHANGED;
        next_currentScale  = `CNP_CODE_UNCHANGED;
        case (zoneSync)
            `CNP_ZONE_WARM: begin
                next_voltageOffset = threshControlA[`CNP_WARMV_HI:`CNP_WARMV_LO];
            end
            `CNP_ZONE_PREWARM: begin
                next_voltageOffset = profileControlB[`CNP_PREWV_HI:`CNP_PREWV_LO];
                next_currentScale  = profileControlB[`CNP_PREWI_HI:`CNP_PREWI_LO];
            end
            `CNP_ZONE_COOL: begin
                // Cool borrows the warm setting only when mirroring is on.
                if (profileControlB[`CNP_MIRROR_BIT]) begin
                    next_voltageOffset = threshControlA[`CNP_WARMV_HI:`CNP_WARMV_LO];
                end
            end
            `CNP_ZONE_PRECOOL: begin
                if (profileControlB[`CNP_MIRROR_BIT]) begin
                    next_voltageOffset = profileControlB[`CNP_PREWV_HI:`CNP_PREWV_LO];
                end
                next_currentScale = profileControlB[`CNP_PRECI_HI:`CNP_PRECI_LO];
            end
            `CNP_ZONE_COLD, `CNP_ZONE_HOT, `CNP_ZONE_BIASFAULT: begin
                // Out-of-range zones and a bias fault stop charging.
                next_currentScale = `CNP_CODE_SUSPEND;
            end
            default: begin
                // Normal zone leaves both targets alone.
                next_currentScale = `CNP_CODE_UNCHANGED;
            end
        endcase
    end

    // Settings outputs are registered copies of the fields and zone derating.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            coldSideThresholdSelect <= RST_THRESH[`CNP_COLD_HI:`CNP_COLD_LO];
            hotSideThresholdSelect  <= RST_THRESH[`CNP_HOT_HI:`CNP_HOT_LO];
            voltageOffsetCode       <= `CNP_CODE_UNCHANGED;
            currentScaleCode        <= `CNP_CODE_UNCHANGED;
        end else begin
            coldSideThresholdSelect <= threshControlA[`CNP_COLD_HI:`CNP_COLD_LO];
            hotSideThresholdSelect  <= threshControlA[`CNP_HOT_HI:`CNP_HOT_LO];
            voltageOffsetCode       <= next_voltageOffset;
            currentScaleCode        <= next_currentScale;
        end
    end

    // Serial engine: samples data on clock rise, changes data on clock fall.
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclPrev         <= 1'b0;
            sdaPrev         <= 1'b0;
            state           <= ST_IDLE;
            kind            <= KIND_DEV;
            bitCnt          <= 4'h0;
            shiftReg        <= 8'h00;
            regPtr          <= 8'h00;
            readDir         <= 1'b0;
            hostAcked       <= 1'b0;
            sdaOut          <= 1'b0;
            sdaOe           <= 1'b0;
            threshControlA  <= `CNP_RST_THRESH_A;
            profileControlB <= `CNP_RST_PROFILE_B;
        end else begin
            sclPrev <= sclNow;
            sdaPrev <= sdaNow;
            sdaOut  <= 1'b0;
            if (startSeen) begin
                // A start, repeated or not, always begins a new address byte.
                state  <= ST_RX;
                kind   <= KIND_DEV;
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
            end else if (stopSeen) begin
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (sclRise) begin
                            shiftReg <= {shiftReg[6:0], sdaNow};
                            bitCnt   <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == `CNP_BITS_PER_BYTE) begin
                            state <= ST_ACK;
                            sdaOe <= 1'b1;
                            if (kind == KIND_DEV) begin
                                // Stay silent unless the address is ours.
                                if (shiftReg[7:1] == DEV_ADDR) begin
                                    readDir <= shiftReg[0];
                                end else begin
                                    state <= ST_IDLE;
                                    sdaOe <= 1'b0;
                                end
                            end else if (kind == KIND_REG) begin
                                regPtr <= shiftReg;
                                kind   <= KIND_DATA;
                            end else begin
                                // Writes land only in writable bits of mapped registers.
                                if (regPtr == `CNP_ADDR_THRESH_A) begin
                                    threshControlA <= shiftReg;
                                end else if (regPtr == `CNP_ADDR_PROFILE_B) begin
                                    profileControlB <= shiftReg & `CNP_MASK_PROFILE_B;
                                end
                                regPtr <= regPtr + 8'h01;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (kind == KIND_DEV && readDir) begin
                                // Put the first read bit out as the acknowledge ends.
                                shiftReg <= readByte;
                                sdaOe    <= ~readByte[7];
                                regPtr   <= regPtr + 8'h01;
                                state    <= ST_TX;
                            end else begin
                                if (kind == KIND_DEV) begin
                                    kind <= KIND_REG;
                                end
                                sdaOe <= 1'b0;
                                state <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (sclFall) begin
                            if (bitCnt == `CNP_LAST_TX_BIT) begin
                                sdaOe <= 1'b0;
                                state <= ST_MACK;
                            end else begin
                                sdaOe    <= ~shiftReg[6];
                                shiftReg <= {shiftReg[6:0], 1'b0};
                                bitCnt   <= bitCnt + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (sclRise) begin
                            hostAcked <= ~sdaNow;
                        end else if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (hostAcked) begin
                                shiftReg <= readByte;
                                sdaOe    <= ~readByte[7];
                                regPtr   <= regPtr + 8'h01;
                                state    <= ST_TX;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* tb/cnp_regs_props.sv */
// Concurrent checks on the pins of the thermistor profile and status register slice.
`timescale 1ns/1ps
`default_nettype none
`include "cnp_consts.vh"

module cnp_regs_props (
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Serial port pins.
    input wire logic       sclIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    // Zone input and settings outputs.
    input wire logic [2:0] zoneCode,
    input wire logic [2:0] coldSideThresholdSelect,
    input wire logic [2:0] hotSideThresholdSelect,
    input wire logic [1:0] voltageOffsetCode,
    input wire logic [1:0] currentScaleCode
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // A zone held long enough to pass the three-flop synchroniser.
    sequence s_normal;
        (zoneCode == `CNP_ZONE_NORMAL) [*8];
    endsequence
    sequence s_halt;
        (zoneCode inside {`CNP_ZONE_COLD, `CNP_ZONE_HOT, `CNP_ZONE_BIASFAULT}) [*8];
    endsequence
    sequence s_warm_cool;
        (zoneCode inside {`CNP_ZONE_WARM, `CNP_ZONE_COOL}) [*8];
    endsequence
    // Reset released while the pre-warm zone is present.
    sequence s_release_prewarm;
        $fell(sys_rst) ##1 (zoneCode == `CNP_ZONE_PREWARM) [*8];
    endsequence

    property p_drain_low;
        sdaOut == 1'b0;
    endproperty
    property p_data_on_low_clock;
        $changed(sdaOe) |-> !sclIn;
    endproperty
    property p_thresh_reset;
        $fell(sys_rst) |-> hotSideThresholdSelect == 3'h1 && coldSideThresholdSelect == 3'h1;
    endproperty
    property p_thresh_on_ack;
        $changed({coldSideThresholdSelect, hotSideThresholdSelect}) |-> sdaOe;
    endproperty
    property p_normal;
        s_normal |-> voltageOffsetCode == 2'h3 && currentScaleCode == 2'h3;
    endproperty
    property p_halt;
        s_halt |-> currentScaleCode == `CNP_CODE_SUSPEND && voltageOffsetCode == 2'h3;
    endproperty
    property p_warm_current;
        s_warm_cool |-> currentScaleCode == `CNP_CODE_UNCHANGED;
    endproperty
    property p_reset_prewarm;
        s_release_prewarm |-> voltageOffsetCode == 2'h3 && currentScaleCode == 2'h3;
    endproperty

    a_drain_low: assert property (p_drain_low) else $error("data pin driven high");
    a_data_on_low_clock: assert property (p_data_on_low_clock)
        else $error("data pin moved while clock high");
    a_thresh_reset: assert property (p_thresh_reset) else $error("threshold reset wrong");
    a_thresh_on_ack: assert property (p_thresh_on_ack) else $error("threshold moved off a write");
    a_normal: assert property (p_normal) else $error("normal zone derated");
    a_halt: assert property (p_halt) else $error("charging not suspended");
    a_warm_current: assert property (p_warm_current) else $error("warm current scaled");
    a_reset_prewarm: assert property (p_reset_prewarm)
        else $error("pre-warm derating after reset wrong");
endmodule
`default_nettype wire

/* tb/cnp_host.sv */
// Serial host model that drives the clock and data pins of the register slice.
`timescale 1ns/1ps
`default_nettype none

module cnp_host #(
    parameter logic [6:0] ADDR = 7'h35, // Target address, value arbitrary.
    parameter int         HALF = 12     // Cycles in the high clock phase of a bit; the low phase is four longer.
) (
    // Clock.
    input  wire logic sys_clk,
    // Data pin drive from the slice.
    input  wire logic sdaOut,
    input  wire logic sdaOe,
    // Resolved pin levels seen by the slice.
    output logic      sclIn,
    output logic      sdaIn
);
    logic hostSda   = 1'b1; // Host side of the data line, high when released.
    int   nackCount = 0;    // Bytes the slice failed to acknowledge.

    // The pulled-up line is low when either party pulls it.
    assign sdaIn = hostSda & (sdaOe ? sdaOut : 1'b1);
    initial sclIn = 1'b1;

    // Waits n cycles, then steps just past the edge.
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start;
        wt(4);
        hostSda = 1'b1;
        wt(HALF);
        sclIn = 1'b1;
        wt(HALF);
        hostSda = 1'b0;
        wt(HALF);
        sclIn = 1'b0;
    endtask
    // Stop: data rises while the clock is high; the clock then stands high.
    task automatic stop;
        wt(4);
        hostSda = 1'b0;
        wt(HALF);
        sclIn = 1'b1;
        wt(HALF);
        hostSda = 1'b1;
        wt(HALF);
    endtask
    // One bit; data changes only a few cycles after the clock fell.
    task automatic bitx(input logic b, output logic r);
        wt(4);
        hostSda = b;
        wt(HALF);
        sclIn = 1'b1;
        wt(HALF);
        r = sdaIn;
        sclIn = 1'b0;
    endtask
    // Eight bits most significant first, then the acknowledge bit.
    task automatic xbyte(input logic [7:0] d, input logic ackIn,
                         output logic [7:0] q, output logic ackOut);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(ackIn, ackOut);
    endtask
    // Sends a byte and counts a missing acknowledge.
    task automatic send(input logic [7:0] d);
        logic [7:0] q;
        logic       a;
        xbyte(d, 1'b1, q, a);
        if (a !== 1'b0) nackCount++;
    endtask
    // Writes one register.
    task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
        start;
        send({ADDR, 1'b0});
        send(ptr);
        send(data);
        stop;
    endtask
    // Reads one register; the last byte is refused so the slice lets go.
    task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
        logic a;
        start;
        send({ADDR, 1'b0});
        send(ptr);
        start;
        send({ADDR, 1'b1});
        xbyte(8'hFF, 1'b1, data, a);
        stop;
    endtask
endmodule
`default_nettype wire

/* tb/charger_ntc_profile_status_regs_tb_top.sv */
// Self-checking bench for the thermistor profile and live status register slice.
`timescale 1ns/1ps
`default_nettype none
`include "cnp_consts.vh"

`define CHK(name, exp, got) check_val(name, exp, got)

module charger_ntc_profile_status_regs_tb_top;
    logic       sys_clk  = 1'b0;             // 200 MHz clock.
    logic       sys_rst  = 1'b1;             // Active-high reset.
    logic [9:0] st       = 10'h000;          // Live conditions, one-shot done down to watchdog.
    logic [2:0] zoneCode = `CNP_ZONE_PREWARM; // Present thermistor zone.
    wire        sclIn, sdaIn, sdaOut, sdaOe; // Serial pins.
    wire  [2:0] coldSel, hotSel;             // Threshold selections.
    wire  [1:0] vCode, iCode;                // Derating codes.
    logic [7:0] rdat;                        // Last byte read.
    int         n_errors = 0;
    int         n_tests  = 0;

    always #2.5 sys_clk = ~sys_clk;

    // The slice, with every live condition driven from the bench.
    cnp_regs #(.DEV_ADDR(7'h35)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .adcOneShotDone(st[9]), .adcContinuous(st[8]),
        .forwardMode(st[7]), .dieThermalRegulating(st[6]), .batteryBelowMinSystem(st[5]),
        .inputCurrentLoop(st[4]), .pinCurrentLimitLoop(st[3]), .inputVoltageLoop(st[2]),
        .chargeTimerExpired(st[1]), .hostWatchdogExpired(st[0]), .zoneCode(zoneCode),
        .coldSideThresholdSelect(coldSel), .hotSideThresholdSelect(hotSel),
        .voltageOffsetCode(vCode), .currentScaleCode(iCode));

    // The serial host on the far side.
    cnp_host #(.ADDR(7'h35), .HALF(12)) host_u (
        .sys_clk(sys_clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

    // Expected status byte; the forward-mode bits are gated.
    function automatic logic [7:0] exp_st(input logic [9:0] s);
        return {1'b0, s[9] & ~s[8], s[6], s[7] & s[5], s[7] & (s[4] | s[3]), s[7] & s[2],
                s[1], s[0]};
    endfunction
    // Expected {voltage, current} codes with warm 0, pre-warm 1 and 2, pre-cool 1.
    function automatic logic [3:0] exp_dr(input logic [2:0] z, input logic m);
        case (z)
            3'h0: return 4'hF;
            3'h3: return m ? 4'h3 : 4'hF;
            3'h4: return 4'h3;
            3'h5: return m ? 4'h5 : 4'hD;
            3'h6: return 4'h6;
            default: return 4'hC;
        endcase
    endfunction
    // Waits n cycles, then steps just past the edge.
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Compares and counts one value.
    task automatic check_val(input string name, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Cuts a hang short at about 2.4 times the expected run.
    initial begin
        #500000;
        n_errors++;
        report_and_stop;
    end

    // Main sequence.
    initial begin
        tick(8);
        sys_rst = 1'b0;
        tick(12);
        `CHK("hot select", 8'h01, {5'h00, hotSel});
        `CHK("derate reset", 8'h0F, {4'h0, vCode, iCode});
        host_u.rd(`CNP_ADDR_PROFILE_B, rdat);
        `CHK("profile reset", 8'h3F, rdat);
        host_u.rd(`CNP_ADDR_THRESH_A, rdat);
        `CHK("thresh reset", `CNP_RST_THRESH_A, rdat);
        host_u.rd(`CNP_ADDR_STATUS_A, rdat);
        `CHK("status reset", 8'h00, rdat);
        // Reserved and read-only bits refuse ones.
        host_u.wr(`CNP_ADDR_PROFILE_B, 8'hFF);
        host_u.rd(`CNP_ADDR_PROFILE_B, rdat);
        `CHK("profile all ones", 8'h7F, rdat);
        host_u.wr(`CNP_ADDR_STATUS_A, 8'hFF);
        host_u.rd(`CNP_ADDR_STATUS_A, rdat);
        `CHK("status write", 8'h00, rdat);
        // Every hot threshold code; the last leaves warm offset 0.
        for (int h = 7; h >= 0; h--) begin
            host_u.wr(`CNP_ADDR_THRESH_A, {3'(7-h), 3'(h), 2'h0});
            tick(4);
            `CHK("thresholds", {2'h0, 3'(7-h), 3'(h)}, {2'h0, coldSel, hotSel});
        end
        // Every zone, with the cool zones mirroring warm off and on.
        for (int m = 0; m < 2; m++) begin
            host_u.wr(`CNP_ADDR_PROFILE_B, m ? 8'h59 : 8'h19);
            for (int z = 0; z < 8; z++) begin
                zoneCode = 3'(z);
                tick(12);
                `CHK("derate", {4'h0, exp_dr(3'(z), m[0])}, {4'h0, vCode, iCode});
            end
        end
        // Each live condition alone, outside and inside forward mode.
        for (int i = 0; i < 20; i++) begin
            st = (10'h001 << (i % 10)) | (i >= 10 ? 10'h080 : 10'h000);
            tick(12);
            host_u.rd(`CNP_ADDR_STATUS_A, rdat);
            `CHK("status", exp_st(st), rdat);
        end
        host_u.rd(`CNP_ADDR_STATUS_A, rdat);
        `CHK("status reread", 8'h40, rdat);
        st = 10'h300;
        tick(12);
        host_u.rd(`CNP_ADDR_STATUS_A, rdat);
        `CHK("continuous done", 8'h00, rdat);
        // Reset in mid-run restores the profile.
        zoneCode = `CNP_ZONE_PREWARM;
        sys_rst = 1'b1;
        tick(8);
        sys_rst = 1'b0;
        tick(12);
        host_u.rd(`CNP_ADDR_PROFILE_B, rdat);
        `CHK("profile after reset", 8'h3F, rdat);
        `CHK("missing acks", 8'h00, 8'(host_u.nackCount));
        report_and_stop;
    end
endmodule

bind cnp_regs cnp_regs_props chk_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .zoneCode(zoneCode), .coldSideThresholdSelect(coldSideThresholdSelect),
    .hotSideThresholdSelect(hotSideThresholdSelect),
    .voltageOffsetCode(voltageOffsetCode), .currentScaleCode(currentScaleCode));
`default_nettype wire
